/* File: verilog/sfep_consts.vh */
// Constants shared by the serial flash erase, program and protection sequencer
`ifndef SFEP_CONSTS_VH
`define SFEP_CONSTS_VH
// ==========================================
// Opcodes and sequence bytes
`define SFEP_OP_SECT_ERASE 8'h7C
`define SFEP_OP_PROG_BUF1 8'h82
`define SFEP_OP_PROG_BUF2 8'h85
`define SFEP_OP_CHIP_ERASE 8'hC7
`define SFEP_OP_PROT_SEQ 8'h3D
`define SFEP_CE_BYTE1 8'h94
`define SFEP_CE_BYTE2 8'h80
`define SFEP_CE_BYTE3 8'h9A
`define SFEP_PS_BYTE1 8'h2A
`define SFEP_PS_BYTE2 8'h7F
`define SFEP_PS_ENABLE 8'hA9
`define SFEP_PS_DISABLE 8'h9A
// ==========================================
// Geometry and protection map
`define SFEP_NUM_SECT 16
`define SFEP_NUM_SLOT 17
`define SFEP_MAP_PROT 8'hFF
`define SFEP_PAGE_264 9'h108
`define SFEP_PAGE_256 9'h100
`define SFEP_BUF_WORDS 528
`define SFEP_CMD_BYTES 3'h4
`define SFEP_LAST_BIT 3'h7
// ==========================================
// Operation kinds driven to the array
`define SFEP_KIND_NONE 2'h0
`define SFEP_KIND_SECT 2'h1
`define SFEP_KIND_CHIP 2'h2
`define SFEP_KIND_PROG 2'h3
// ==========================================
// Timing: clock rate and self-timed durations in microseconds
`define SFEP_CLK_MHZ 20
`define SFEP_T_SECT_US 100000
`define SFEP_T_CHIP_US 1000000
`define SFEP_T_PROG_US 40000
`endif

/* File: verilog/sfep_sync.v */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sfep_sync #(
  parameter RST_VAL = 1'b0
) (
  input wire clock,
  input wire nrst,
  input wire din,
  output reg dout
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  // ==========================================
  // Sampling chain
  // Only s2 feeds s3; the filter compares the two settled stages
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        dout <= s3_ff;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verilog/sfep_timer.v */
// Down counter timing the self-timed erase and program cycles
`timescale 1ns/1ps
`default_nettype none
module sfep_timer #(
  parameter WIDTH = 32
) (
  input wire clock,
  input wire nrst,
  input wire start,
  input wire [WIDTH-1:0] load,
  output reg done_ff
);
  reg [WIDTH-1:0] cnt_ff;
  reg run_ff;
  // ==========================================
  // Count
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= {WIDTH{1'b0}};
      run_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start) begin
        cnt_ff <= load;
        run_ff <= 1'b1;
      end else if (run_ff) begin
        if (cnt_ff <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          run_ff <= 1'b0;
          done_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: verilog/sfep_core.v */
// Serial flash command decode, erase/program sequencing and sector protection
`timescale 1ns/1ps
`default_nettype none
`include "sfep_consts.vh"
module sfep_core #(
  parameter T_SECT_US = `SFEP_T_SECT_US,
  parameter T_CHIP_US = `SFEP_T_CHIP_US,
  parameter T_PROG_US = `SFEP_T_PROG_US
) (
  input wire clock,
  input wire nrst,
  input wire cs_n,
  input wire sck,
  input wire si,
  input wire wp_n,
  input wire page256,
  input wire [127:0] prot_map,
  input wire [16:0] lock_map,
  input wire rd_buf,
  input wire [8:0] rd_addr,
  output reg busy_ff,
  output reg prot_status_ff,
  output reg op_go_ff,
  output reg [1:0] op_kind_ff,
  output reg [11:0] op_page_ff,
  output reg op_buf_ff,
  output reg [16:0] op_mask_ff,
  output reg [7:0] rd_data_ff
);
  // ==========================================
  // Derived cycle counts
  localparam [31:0] SECT_CYC = T_SECT_US * `SFEP_CLK_MHZ;
  localparam [31:0] CHIP_CYC = T_CHIP_US * `SFEP_CLK_MHZ;
  localparam [31:0] PROG_CYC = T_PROG_US * `SFEP_CLK_MHZ;
  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;

  // ==========================================
  // Functions
  // Page number from the 24-bit address in either page mode
  function [11:0] page_of;
    input [23:0] a;
    input bin;
    begin
      if (bin) begin
        page_of = a[19:8];
      end else begin
        page_of = a[20:9];
      end
    end
  endfunction

  // Slot 0 is 0a, slot 1 is 0b, slots 2..16 are sectors 1..15
  function [4:0] sector_of;
    input [11:0] pg;
    begin
      if (pg[11:8] == 4'h0) begin
        sector_of = {4'h0, pg[3]};
      end else begin
        sector_of = {1'b0, pg[11:8]} + 5'h01;
      end
    end
  endfunction

  function [16:0] prot_mask;
    input [127:0] map;
    input [16:0] lck;
    input active;
    integer i;
    begin
      prot_mask[0] = &map[7:6];
      prot_mask[1] = &map[5:4];
      for (i = 1; i < `SFEP_NUM_SECT; i = i + 1) begin
        prot_mask[i+1] = (map[i*8 +: 8] == `SFEP_MAP_PROT);
      end
      prot_mask = (active ? prot_mask : 17'h0_0000) | lck;
    end
  endfunction

  function [9:0] buf_index;
    input sel;
    input [8:0] off;
    begin
      buf_index = (sel ? {1'b0, `SFEP_PAGE_264} : 10'h000) + {1'b0, off};
    end
  endfunction

  // ==========================================
  // Pin synchronisers
  wire cs_n_s;
  wire sck_s;
  wire si_s;
  wire wp_n_s;

  sfep_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .clock(clock),
    .nrst(nrst),
    .din(cs_n),
    .dout(cs_n_s)
  );
  sfep_sync #(.RST_VAL(1'b0)) u_sync_sck (
    .clock(clock),
    .nrst(nrst),
    .din(sck),
    .dout(sck_s)
  );
  sfep_sync #(.RST_VAL(1'b0)) u_sync_si (
    .clock(clock),
    .nrst(nrst),
    .din(si),
    .dout(si_s)
  );
  // Pin is pulled high when left open, so idle is deasserted
  sfep_sync #(.RST_VAL(1'b1)) u_sync_wp (
    .clock(clock),
    .nrst(nrst),
    .din(wp_n),
    .dout(wp_n_s)
  );

  // ==========================================
  // Edges and serial shift
  reg sck_d_ff;
  reg cs_d_ff;
  reg [2:0] bit_cnt_ff;
  reg [6:0] shift_ff;
  reg [2:0] byte_cnt_ff;
  reg [7:0] opcode_ff;
  reg [23:0] addr_ff;
  reg seq_ok_ff;
  reg [8:0] buf_ptr_ff;
  reg [7:0] buf_mem [0:`SFEP_BUF_WORDS-1];
  reg state_ff;
  reg prot_en_ff;
  reg prot_wp_ff;
  reg tmr_start_ff;
  reg [31:0] tmr_load_ff;
  wire tmr_done;

  wire sck_rise = sck_s & ~sck_d_ff & ~cs_n_s;
  wire cs_rise = cs_n_s & ~cs_d_ff;
  wire byte_done = sck_rise & (bit_cnt_ff == `SFEP_LAST_BIT);
  wire [7:0] new_byte = {shift_ff, si_s};
  wire wp_asserted = ~wp_n_s;
  wire [8:0] buf_size = page256 ? `SFEP_PAGE_256 : `SFEP_PAGE_264;
  wire is_prog = (opcode_ff == `SFEP_OP_PROG_BUF1) | (opcode_ff == `SFEP_OP_PROG_BUF2);
  wire prog_sel = (opcode_ff == `SFEP_OP_PROG_BUF2);
  wire cmd_full = (byte_cnt_ff == `SFEP_CMD_BYTES);
  wire prot_active = prot_en_ff | prot_wp_ff;
  wire [11:0] cur_page = page_of(addr_ff, page256);
  wire [4:0] cur_sect = sector_of(cur_page);
  wire [16:0] cur_prot = prot_mask(prot_map, lock_map, prot_active);
  wire [16:0] cur_onehot = 17'h0_0001 << cur_sect;
  wire [23:0] addr_next = {addr_ff[15:0], new_byte};
  wire [8:0] start_off = page256 ? {1'b0, addr_next[7:0]} : addr_next[8:0];

  // Expected bytes 2 and 3 of four-byte sequences; byte 4 is checked at release
  wire [7:0] exp_byte = (opcode_ff == `SFEP_OP_CHIP_ERASE) ?
    ((byte_cnt_ff == 3'h1) ? `SFEP_CE_BYTE1 : `SFEP_CE_BYTE2) :
    ((byte_cnt_ff == 3'h1) ? `SFEP_PS_BYTE1 : `SFEP_PS_BYTE2);

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sck_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
      bit_cnt_ff <= 3'h0;
      shift_ff <= 7'h00;
      byte_cnt_ff <= 3'h0;
      opcode_ff <= 8'h00;
      addr_ff <= 24'h00_0000;
      seq_ok_ff <= 1'b0;
      buf_ptr_ff <= 9'h000;
    end else begin
      sck_d_ff <= sck_s;
      cs_d_ff <= cs_n_s;
      if (cs_n_s) begin
        // Deselect drops any partial command
        bit_cnt_ff <= 3'h0;
        byte_cnt_ff <= 3'h0;
      end else if (sck_rise) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        shift_ff <= new_byte[6:0];
        if (byte_done) begin
          if (byte_cnt_ff == 3'h0) begin
            opcode_ff <= new_byte;
            seq_ok_ff <= 1'b1;
          end else if (!cmd_full) begin
            addr_ff <= addr_next;
            if (byte_cnt_ff != 3'h3) begin
              seq_ok_ff <= seq_ok_ff & (new_byte == exp_byte);
            end else if (is_prog) begin
              buf_ptr_ff <= (start_off < buf_size) ? start_off : 9'h000;
            end
          end else if (is_prog && state_ff == ST_IDLE) begin
            // Data phase; wrap keeps the write inside the chosen buffer
            if (buf_ptr_ff + 9'h001 == buf_size) begin
              buf_ptr_ff <= 9'h000;
            end else begin
              buf_ptr_ff <= buf_ptr_ff + 9'h001;
            end
          end
          // Count stops at a full sequence; later bytes are dropped unless they are program data
          if (!cmd_full) begin
            byte_cnt_ff <= byte_cnt_ff + 3'h1;
          end
        end
      end
    end
  end

  // ==========================================
  // Buffer storage and read port
  // No reset on the data array: contents are undefined at power-up
  always @(posedge clock) begin
    if (byte_done && cmd_full && is_prog && state_ff == ST_IDLE) begin
      buf_mem[buf_index(prog_sel, buf_ptr_ff)] <= new_byte;
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_data_ff <= 8'h00;
    end else if (rd_addr < `SFEP_PAGE_264) begin
      rd_data_ff <= buf_mem[buf_index(rd_buf, rd_addr)];
    end else begin
      rd_data_ff <= 8'h00;
    end
  end

  // ==========================================
  // Self-timed operation sequencer
  sfep_timer #(.WIDTH(32)) u_timer (
    .clock(clock),
    .nrst(nrst),
    .start(tmr_start_ff),
    .load(tmr_load_ff),
    .done_ff(tmr_done)
  );

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      busy_ff <= 1'b0;
      prot_en_ff <= 1'b0;
      prot_wp_ff <= 1'b0;
      prot_status_ff <= 1'b0;
      op_go_ff <= 1'b0;
      op_kind_ff <= `SFEP_KIND_NONE;
      op_page_ff <= 12'h000;
      op_buf_ff <= 1'b0;
      op_mask_ff <= 17'h0_0000;
      tmr_start_ff <= 1'b0;
      tmr_load_ff <= 32'h0000_0000;
    end else begin
      op_go_ff <= 1'b0;
      tmr_start_ff <= 1'b0;
      prot_status_ff <= prot_active;
      case (state_ff)
        ST_IDLE: begin
          // Pin protection is only resampled between operations
          prot_wp_ff <= wp_asserted;
          if (cs_rise && cmd_full) begin
            if (opcode_ff == `SFEP_OP_SECT_ERASE) begin
              if (!(|(cur_prot & cur_onehot))) begin
                state_ff <= ST_BUSY;
                busy_ff <= 1'b1;
                op_go_ff <= 1'b1;
                op_kind_ff <= `SFEP_KIND_SECT;
                op_page_ff <= cur_page;
                op_mask_ff <= cur_onehot;
                tmr_start_ff <= 1'b1;
                tmr_load_ff <= SECT_CYC;
              end
            end else if (is_prog) begin
              if (!(|(cur_prot & cur_onehot))) begin
                state_ff <= ST_BUSY;
                busy_ff <= 1'b1;
                op_go_ff <= 1'b1;
                op_kind_ff <= `SFEP_KIND_PROG;
                op_page_ff <= cur_page;
                op_buf_ff <= prog_sel;
                op_mask_ff <= cur_onehot;
                tmr_start_ff <= 1'b1;
                tmr_load_ff <= PROG_CYC;
              end
            end else if (opcode_ff == `SFEP_OP_CHIP_ERASE && seq_ok_ff &&
                         addr_ff[7:0] == `SFEP_CE_BYTE3) begin
              state_ff <= ST_BUSY;
              busy_ff <= 1'b1;
              op_go_ff <= 1'b1;
              op_kind_ff <= `SFEP_KIND_CHIP;
              op_page_ff <= 12'h000;
              op_mask_ff <= ~cur_prot;
              tmr_start_ff <= 1'b1;
              tmr_load_ff <= CHIP_CYC;
            end else if (opcode_ff == `SFEP_OP_PROT_SEQ && seq_ok_ff) begin
              if (addr_ff[7:0] == `SFEP_PS_ENABLE) begin
                prot_en_ff <= 1'b1;
              end else if (addr_ff[7:0] == `SFEP_PS_DISABLE && !wp_asserted) begin
                prot_en_ff <= 1'b0;
              end
            end
          end
        end
        ST_BUSY: begin
          // Busy holds until the timer reports the cycle finished
          if (tmr_done) begin
            state_ff <= ST_IDLE;
            busy_ff <= 1'b0;
            op_kind_ff <= `SFEP_KIND_NONE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          busy_ff <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: tb/sfep_core_sva.sv */
// Assertion checker for the flash sequencer outputs
`timescale 1ns/1ps
`default_nettype none
module sfep_core_sva #(
  parameter T_SECT_US = 1,
  parameter T_CHIP_US = 1,
  parameter T_PROG_US = 1
) (
  input wire clock,
  input wire nrst,
  input wire [127:0] prot_map,
  input wire [16:0] lock_map,
  input wire busy_ff,
  input wire prot_status_ff,
  input wire op_go_ff,
  input wire [1:0] op_kind_ff,
  input wire [16:0] op_mask_ff
);
  logic [16:0] guard;
  logic [31:0] run_ff;
  logic [31:0] lim;
  // ==========================================
  // Slots that must never be touched right now
  always_comb begin
    guard = lock_map;
    if (prot_status_ff) begin
      guard[0] = guard[0] | (prot_map[7:6] == 2'h3);
      guard[1] = guard[1] | (prot_map[5:4] == 2'h3);
      for (int k = 1; k < 16; k++) begin
        guard[k+1] = guard[k+1] | (prot_map[8*k+:8] == 8'hFF);
      end
    end
  end
  // Busy length is counted, a repetition would be far too long to unroll
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      run_ff <= 32'h0;
    end else if (busy_ff) begin
      run_ff <= run_ff + 32'h1;
    end else begin
      run_ff <= 32'h0;
    end
  end
  assign lim = 20 * ((op_kind_ff == 2'h2) ? T_CHIP_US : (op_kind_ff == 2'h3) ? T_PROG_US : T_SECT_US);
  // ==========================================
  // Properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_launch;
    op_go_ff && busy_ff;
  endsequence
  sequence s_hold;
    !op_go_ff && busy_ff;
  endsequence
  a_go_pulse: assert property (op_go_ff |-> s_launch ##1 s_hold)
    else $error("start pulse not single or not busy");
  a_busy_start: assert property ($rose(busy_ff) |-> op_go_ff)
    else $error("busy rose without start");
  a_kind_held: assert property (busy_ff && $past(busy_ff) |-> $stable(op_kind_ff))
    else $error("operation kind changed while busy");
  a_kind_idle: assert property (!busy_ff && !$past(busy_ff) |-> op_kind_ff == 2'h0)
    else $error("operation kind set while idle");
  a_busy_len: assert property ($fell(busy_ff) |->
    ($past(run_ff) + 32'h3 >= $past(lim)) && ($past(run_ff) <= $past(lim) + 32'h3))
    else $error("busy length wrong");
  a_one_slot: assert property (op_go_ff && op_kind_ff != 2'h2 |-> $onehot(op_mask_ff))
    else $error("more than one slot selected");
  a_chip_mask: assert property (op_go_ff && op_kind_ff == 2'h2 |-> op_mask_ff == ~guard)
    else $error("chip erase mask wrong");
  a_prot_refuse: assert property (op_go_ff |-> (op_mask_ff & guard) == 17'h0)
    else $error("guarded slot selected");
  a_prot_steady: assert property (busy_ff && $past(busy_ff, 2) |-> $stable(prot_status_ff))
    else $error("protection changed mid operation");
endmodule
bind sfep_core sfep_core_sva #(.T_SECT_US(T_SECT_US), .T_CHIP_US(T_CHIP_US),
  .T_PROG_US(T_PROG_US)) chk (.clock(clock), .nrst(nrst), .prot_map(prot_map),
  .lock_map(lock_map), .busy_ff(busy_ff), .prot_status_ff(prot_status_ff),
  .op_go_ff(op_go_ff), .op_kind_ff(op_kind_ff), .op_mask_ff(op_mask_ff));
`default_nettype wire

/* File: tb/sfep_host.sv */
// Host serial master model driving chip select, serial clock and data
`timescale 1ns/1ps
`default_nettype none
module sfep_host (
  input wire logic clock,
  output var logic cs_n,
  output var logic sck,
  output var logic si
);
  logic [7:0] q[$];
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b1;
  end
  task automatic hstep(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  // Mode 0, MSB first; clock parked low outside frames
  task automatic xfer();
    logic [7:0] b;
    hstep(1);
    cs_n = 1'b0;
    while (q.size() > 0) begin
      b = q.pop_front();
      for (int i = 7; i >= 0; i--) begin
        si = b[i];
        hstep(4);
        sck = 1'b1;
        hstep(4);
        sck = 1'b0;
      end
    end
    hstep(4);
    cs_n = 1'b1;
    // Released data line must not look like a held bit
    si = ~si;
  endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic wp_n;
  logic page256;
  logic [127:0] prot_map;
  logic [16:0] lock_map;
  logic rd_buf;
  logic [8:0] rd_addr;
  wire logic cs_n;
  wire logic sck;
  wire logic si;
  wire logic busy_ff;
  wire logic prot_status_ff;
  wire logic op_go_ff;
  wire logic op_buf_ff;
  wire logic [1:0] op_kind_ff;
  wire logic [11:0] op_page_ff;
  wire logic [16:0] op_mask_ff;
  wire logic [7:0] rd_data_ff;
  int bad_count = 0;
  int checked = 0;
  int go_n = 0;
  int cyc = 0;
  logic [1:0] g_kind;
  logic [11:0] g_page;
  logic g_buf;
  logic [16:0] g_mask;
  always #25 clock = ~clock;
  sfep_host host (.clock(clock), .cs_n(cs_n), .sck(sck), .si(si));
  sfep_core #(.T_SECT_US(1), .T_CHIP_US(1), .T_PROG_US(1)) dut (.clock(clock), .nrst(nrst),
    .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .page256(page256), .prot_map(prot_map),
    .lock_map(lock_map), .rd_buf(rd_buf), .rd_addr(rd_addr), .busy_ff(busy_ff),
    .prot_status_ff(prot_status_ff), .op_go_ff(op_go_ff), .op_kind_ff(op_kind_ff),
    .op_page_ff(op_page_ff), .op_buf_ff(op_buf_ff), .op_mask_ff(op_mask_ff),
    .rd_data_ff(rd_data_ff));
  task automatic complete_run();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Timeout and capture of each launched operation
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
    if (op_go_ff === 1'b1) begin
      go_n++;
      g_kind = op_kind_ff;
      g_page = op_page_ff;
      g_buf = op_buf_ff;
      g_mask = op_mask_ff;
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy_ff !== 1'b0 && k < 200) begin
      step(1);
      k++;
    end
    `CHK("idle", 1'b0, busy_ff)
  endtask
  task automatic send(input logic [7:0] op, input logic [23:0] a, input int extra);
    host.q.push_back(op);
    for (int i = 2; i >= 0; i--) host.q.push_back(a[8*i+:8]);
    for (int i = 0; i < extra; i++) host.q.push_back(8'hA0 + 8'(i));
    host.xfer();
  endtask
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int extra, input int go);
    int n0;
    n0 = go_n;
    send(op, a, extra);
    step(12);
    `CHK("go count", go, go_n - n0)
    `CHK("busy", 1'(go), busy_ff)
    wait_idle();
  endtask
  task automatic t_sector();
    logic [11:0] pg [6] = '{12'h000, 12'h008, 12'h0FF, 12'h105, 12'hFFF, 12'h7A3};
    int sl [6] = '{0, 1, 1, 2, 16, 8};
    for (int i = 0; i < 6; i++) begin
      page256 = (i == 5);
      frame(8'h7C, page256 ? {4'h0, pg[i], 8'h00} : {3'h0, pg[i], 9'h000}, 0, 1);
      `CHK("sector kind", 2'h1, g_kind)
      `CHK("sector mask", 17'h1 << sl[i], g_mask)
    end
    page256 = 1'b0;
    $display("sector test done");
  endtask
  task automatic t_chip();
    lock_map = 17'h0_0004;
    frame(8'hC7, 24'h94_809A, 2, 1);
    `CHK("chip kind", 2'h2, g_kind)
    `CHK("chip mask", 17'h1_FFFB, g_mask)
    send(8'hC7, 24'h94_809A, 0);
    step(6);
    wp_n = 1'b0;
    step(8);
    `CHK("busy mid chip", 1'b1, busy_ff)
    `CHK("prot mid chip", 1'b0, prot_status_ff)
    wait_idle();
    step(8);
    `CHK("prot after chip", 1'b1, prot_status_ff)
    wp_n = 1'b1;
    step(8);
    `CHK("prot pin off", 1'b0, prot_status_ff)
    $display("chip test done");
  endtask
  task automatic t_protect();
    prot_map[7:0] = 8'hC0;
    prot_map[31:24] = 8'hFF;
    prot_map[39:32] = 8'hFE;
    frame(8'h3D, 24'h2A_7FA9, 0, 0);
    `CHK("prot on", 1'b1, prot_status_ff)
    frame(8'h7C, {3'h0, 12'h300, 9'h000}, 0, 0);
    frame(8'h7C, {3'h0, 12'h000, 9'h000}, 0, 0);
    frame(8'h7C, {3'h0, 12'h400, 9'h000}, 0, 1);
    `CHK("open sector", 17'h0_0020, g_mask)
    frame(8'hC7, 24'h94_809A, 0, 1);
    `CHK("guarded chip", 17'h1_FFEA, g_mask)
    wp_n = 1'b0;
    step(8);
    frame(8'h3D, 24'h2A_7F9A, 0, 0);
    `CHK("disable refused", 1'b1, prot_status_ff)
    wp_n = 1'b1;
    step(8);
    frame(8'h3D, 24'h2A_7F9A, 0, 0);
    `CHK("prot off", 1'b0, prot_status_ff)
    $display("protect test done");
  endtask
  task automatic t_prog();
    logic [8:0] ra [6] = '{9'h106, 9'h107, 9'h000, 9'h001, 9'h0FF, 9'h000};
    lock_map = 17'h0;
    frame(8'h85, {3'h0, 12'h123, 9'h106}, 4, 1);
    `CHK("prog kind", 2'h3, g_kind)
    `CHK("prog buf", 1'b1, g_buf)
    `CHK("prog page", 12'h123, g_page)
    page256 = 1'b1;
    frame(8'h82, {4'h0, 12'h0A5, 8'hFF}, 2, 1);
    `CHK("prog buf1", 1'b0, g_buf)
    `CHK("prog page256", 12'h0A5, g_page)
    for (int i = 0; i < 6; i++) begin
      rd_buf = (i < 4);
      rd_addr = ra[i];
      step(1);
      `CHK("buffer byte", 8'hA0 + 8'(i % 4), rd_data_ff)
    end
    page256 = 1'b0;
    $display("program test done");
  endtask
  task automatic t_abort();
    int n0;
    n0 = go_n;
    host.q.push_back(8'h7C);
    host.q.push_back(8'h00);
    host.q.push_back(8'h10);
    host.xfer();
    step(12);
    `CHK("short frame", n0, go_n)
    frame(8'hC7, 24'h94_809B, 0, 0);
    $display("abort test done");
  endtask
  // Power cycle in mid-run: software protection must come back disabled
  task automatic t_power();
    frame(8'h3D, 24'h2A_7FA9, 0, 0);
    `CHK("prot before cycle", 1'b1, prot_status_ff)
    nrst = 1'b0;
    step(2);
    `CHK("prot in reset", 1'b0, prot_status_ff)
    nrst = 1'b1;
    step(6);
    `CHK("prot after cycle", 1'b0, prot_status_ff)
    frame(8'h7C, {3'h0, 12'h000, 9'h000}, 0, 1);
    `CHK("open after cycle", 17'h0_0001, g_mask)
    $display("power cycle test done");
  endtask
  initial begin
    wp_n = 1'b1;
    page256 = 1'b0;
    prot_map = 128'h0;
    lock_map = 17'h0_0000;
    rd_buf = 1'b0;
    rd_addr = 9'h000;
    repeat (4) @(posedge clock);
    #2;
    nrst = 1'b1;
    step(6);
    `CHK("power-up prot", 1'b0, prot_status_ff)
    t_sector();
    t_chip();
    t_protect();
    t_prog();
    t_power();
    t_abort();
    complete_run();
  end
endmodule
`default_nettype wire
